// *** logic/cmp_ctrl_pkg.sv ***
`default_nettype none
package cmp_ctrl_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] INT_OFFSET  = 12'h004;
    localparam logic [11:0] DIR_OFFSET  = 12'h008;
    localparam logic [11:0] PORT_OFFSET = 12'h00C;

    // ------------------------------------------------------------
    // comparator_control fields
    // ------------------------------------------------------------
    localparam int CTRL_CMP2_STATUS_BIT = 7;
    localparam int CTRL_CMP1_STATUS_BIT = 6;
    localparam int CTRL_CMP2_INV_BIT    = 5;
    localparam int CTRL_CMP1_INV_BIT    = 4;
    localparam int CTRL_IN_SWITCH_BIT   = 3;
    localparam int CTRL_MODE_MSB        = 2;
    localparam int CTRL_MODE_LSB        = 0;

    // ------------------------------------------------------------
    // interrupt register fields
    // ------------------------------------------------------------
    localparam int INT_FLAG_BIT       = 0;
    localparam int INT_CMP_EN_BIT     = 1;
    localparam int INT_PERIPH_EN_BIT  = 2;
    localparam int INT_GLOBAL_EN_BIT  = 3;

    // ------------------------------------------------------------
    // pin positions within the port
    // ------------------------------------------------------------
    localparam int PIN_CMP1_OUT = 1;
    localparam int PIN_CMP2_OUT = 2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [3:0] INT_RESET  = 4'h0;
    localparam logic [7:0] DIR_RESET  = 8'hFF;

    // ------------------------------------------------------------
    // modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_RESET   = 3'b000,
        MODE_1       = 3'b001,
        MODE_2       = 3'b010,
        MODE_3       = 3'b011,
        MODE_4       = 3'b100,
        MODE_5       = 3'b101,
        MODE_INT_REF = 3'b110,
        MODE_OFF     = 3'b111
    } cmp_mode_e;

    // per-mode tables, one byte (analog mask) or two bits (routing) per mode
    localparam logic [63:0] ANALOG_MASK_TABLE = 64'h007E_7E7E_7E7E_7E7E;
    localparam logic [15:0] PIN_ROUTE_TABLE   = 16'h0000;

endpackage
`default_nettype wire

// *** logic/cmp_sync_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface cmp_sync_if #(
    parameter int WIDTH = 10
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;

    modport syncer
    (
        input  raw,
        output synced
    );
    modport user
    (
        output raw,
        input  synced
    );
endinterface
`default_nettype wire

// *** logic/cmp_input_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module cmp_input_sync #(
    parameter int WIDTH = 10
)
(
    // clock and reset
    input  wire logic    pclk,
    input  wire logic    presetn,
    // raw and synchronised levels
    cmp_sync_if.syncer   sif
);

    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_s;

    sync_state_s state_reg;
    sync_state_s state_next;

    always_comb
    begin
        state_next        = state_reg;
        state_next.stage1 = sif.raw;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    assign sif.synced = state_reg.stage2;

endmodule
`default_nettype wire

// *** logic/cmp_ctrl.sv ***
// Summary of operation
// [R1] non-inverted output high when plus exceeds minus
// [R2] bit5 inverts comparator 2, bit4 comparator 1
// [R3] bits 7,6 show outputs, read-only
// [R4] three-bit mode field selects eight mux modes
// [R5] mode 110 input switch picks alternate inputs
// [R6] mode 110 feeds internal reference to plus
// [R7] outputs may glitch after mode change
// [R8] software disables interrupt before changing mode
// [R9] flag sets on output versus latched mismatch
// [R10] write 0 clears flag, write 1 sets
// [R11] request needs all three enables; flag regardless
// [R12] control access relatches; mismatch keeps setting flag
// [R13] change during control read may be missed
// [R14] comparators and interrupt work during sleep, wake
// [R15] mode 111 powers both comparators off
// [R16] wake leaves control register unchanged
// [R17] reset loads mode 000, comparators powered down
// [R18] routed pins carry unsynchronised comparator output
// [R19] direction bits still enable routed pin drivers
// [R20] port read returns 0 on analog pins
// [R21] comparator outputs pass two-flop synchroniser
// [R22] per-mode pin maps held in parameter tables
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module cmp_ctrl #(
    parameter logic [63:0] ANALOG_MASK_TABLE = cmp_ctrl_pkg::ANALOG_MASK_TABLE,
    parameter logic [15:0] PIN_ROUTE_TABLE   = cmp_ctrl_pkg::PIN_ROUTE_TABLE
)
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // analog comparator outputs, asynchronous
    input  wire logic        cmp1_raw,
    input  wire logic        cmp2_raw,
    // port pin levels, asynchronous
    input  wire logic [7:0]  port_pin_in,
    // analog mux and power control
    output logic [2:0]       comparator_mode_field,
    output logic [1:0]       cmp_power_en,
    output logic             ref_to_noninv,
    output logic             input_switch_alt,
    output logic [7:0]       analog_pin_mask,
    // comparator output pins
    output logic             cmp1_output_pin_o,
    output logic             cmp1_output_pin_oe,
    output logic             cmp2_output_pin_o,
    output logic             cmp2_output_pin_oe,
    // interrupt and wake
    output logic             irq,
    output logic             wake_request
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0]  invert;
        logic        input_switch;
        logic [2:0]  mode;
        logic        flag;
        logic        cmp_int_enable;
        logic        peripheral_int_enable;
        logic        global_int_enable;
        logic [7:0]  port_direction_bits;
        logic [1:0]  latched;
        logic [31:0] rdata;
    } ctrl_state_s;

    ctrl_state_s state_reg;
    ctrl_state_s state_next;

    // ------------------------------------------------------------
    // table lookups
    // ------------------------------------------------------------
    function automatic logic [7:0] mask_of(input logic [2:0] mode);
        mask_of = ANALOG_MASK_TABLE[{mode, 3'b000} +: 8]; // [R22]
    endfunction

    function automatic logic [1:0] route_of(input logic [2:0] mode);
        route_of = PIN_ROUTE_TABLE[{mode, 1'b0} +: 2]; // [R22]
    endfunction

    function automatic logic powered(input logic [2:0] mode);
        powered = (mode != cmp_ctrl_pkg::MODE_RESET) && (mode != cmp_ctrl_pkg::MODE_OFF); // [R15] [R17]
    endfunction

    // ------------------------------------------------------------
    // input synchroniser
    // ------------------------------------------------------------
    cmp_sync_if #(.WIDTH(10)) sif ();

    assign sif.raw = {port_pin_in, cmp2_raw, cmp1_raw};

    cmp_input_sync #(
        .WIDTH (10)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .sif     (sif)
    );

    logic [1:0] cmp_synced;
    logic [7:0] pins_synced;

    assign cmp_synced  = sif.synced[1:0]; // [R21]
    assign pins_synced = sif.synced[9:2];

    // ------------------------------------------------------------
    // comparator outputs after polarity
    // ------------------------------------------------------------
    logic       is_powered;
    logic [1:0] cmp_status;
    logic [1:0] route;

    assign is_powered = powered(state_reg.mode);
    // plus above minus reads high unless inverted; off comparators read low
    assign cmp_status = is_powered ? (cmp_synced ^ state_reg.invert) : 2'b00; // [R1] [R2]
    assign route      = route_of(state_reg.mode);

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic setup_phase;
    logic access_phase;
    logic hit_ctrl;
    logic hit_int;
    logic hit_dir;
    logic hit_port;
    logic hit_any;
    logic wr_en;

    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign hit_ctrl     = (paddr == cmp_ctrl_pkg::CTRL_OFFSET);
    assign hit_int      = (paddr == cmp_ctrl_pkg::INT_OFFSET);
    assign hit_dir      = (paddr == cmp_ctrl_pkg::DIR_OFFSET);
    assign hit_port     = (paddr == cmp_ctrl_pkg::PORT_OFFSET);
    assign hit_any      = hit_ctrl || hit_int || hit_dir || hit_port;
    // only the low byte lane carries register bits
    assign wr_en        = access_phase && pwrite && pstrb[0];

    assign pready  = 1'b1;
    assign pslverr = access_phase && !hit_any;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [1:0] mismatch;

    // comparator changes since the last control access; persists until relatched
    assign mismatch = cmp_status ^ state_reg.latched; // [R9]

    always_comb
    begin
        state_next       = state_reg;
        state_next.rdata = 32'h0000_0000;

        // read data captured in setup so it is a flop in access
        if (setup_phase && !pwrite)
        begin
            if (hit_ctrl)
            begin
                state_next.rdata[cmp_ctrl_pkg::CTRL_CMP2_STATUS_BIT] = cmp_status[1]; // [R3]
                state_next.rdata[cmp_ctrl_pkg::CTRL_CMP1_STATUS_BIT] = cmp_status[0]; // [R3]
                state_next.rdata[cmp_ctrl_pkg::CTRL_CMP2_INV_BIT]    = state_reg.invert[1];
                state_next.rdata[cmp_ctrl_pkg::CTRL_CMP1_INV_BIT]    = state_reg.invert[0];
                state_next.rdata[cmp_ctrl_pkg::CTRL_IN_SWITCH_BIT]   = state_reg.input_switch;
                state_next.rdata[cmp_ctrl_pkg::CTRL_MODE_MSB:cmp_ctrl_pkg::CTRL_MODE_LSB] = state_reg.mode;
            end
            else if (hit_int)
            begin
                state_next.rdata[cmp_ctrl_pkg::INT_FLAG_BIT]      = state_reg.flag;
                state_next.rdata[cmp_ctrl_pkg::INT_CMP_EN_BIT]    = state_reg.cmp_int_enable;
                state_next.rdata[cmp_ctrl_pkg::INT_PERIPH_EN_BIT] = state_reg.peripheral_int_enable;
                state_next.rdata[cmp_ctrl_pkg::INT_GLOBAL_EN_BIT] = state_reg.global_int_enable;
            end
            else if (hit_dir)
            begin
                state_next.rdata[7:0] = state_reg.port_direction_bits;
            end
            else if (hit_port)
            begin
                // analog pins read low whatever their level
                state_next.rdata[7:0] = pins_synced & ~mask_of(state_reg.mode); // [R20]
            end
        end

        // control register: status bits ignore writes
        if (wr_en && hit_ctrl)
        begin
            state_next.invert[1]    = pwdata[cmp_ctrl_pkg::CTRL_CMP2_INV_BIT]; // [R2]
            state_next.invert[0]    = pwdata[cmp_ctrl_pkg::CTRL_CMP1_INV_BIT]; // [R2]
            state_next.input_switch = pwdata[cmp_ctrl_pkg::CTRL_IN_SWITCH_BIT];
            state_next.mode         = pwdata[cmp_ctrl_pkg::CTRL_MODE_MSB:cmp_ctrl_pkg::CTRL_MODE_LSB]; // [R4]
        end

        // any control access ends the mismatch; a change landing in the same
        // cycle still sets the flag before the relatch clears it
        if (access_phase && hit_ctrl)
        begin
            state_next.latched = cmp_status; // [R12] [R13]
        end

        if (wr_en && hit_int)
        begin
            state_next.flag                  = pwdata[cmp_ctrl_pkg::INT_FLAG_BIT]; // [R10]
            state_next.cmp_int_enable        = pwdata[cmp_ctrl_pkg::INT_CMP_EN_BIT];
            state_next.peripheral_int_enable = pwdata[cmp_ctrl_pkg::INT_PERIPH_EN_BIT];
            state_next.global_int_enable     = pwdata[cmp_ctrl_pkg::INT_GLOBAL_EN_BIT];
        end

        if (wr_en && hit_dir)
        begin
            state_next.port_direction_bits = pwdata[7:0];
        end

        // set beats clear: a live mismatch keeps re-raising the flag.
        // mode-change glitches set it too; software masks around them
        if (|mismatch)
        begin
            state_next.flag = 1'b1; // [R9] [R12] [R7] [R8]
        end
    end

    // ------------------------------------------------------------
    // registers; no sleep input, so wake never disturbs them
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg                       <= '0;
            state_reg.invert                <= cmp_ctrl_pkg::CTRL_RESET[cmp_ctrl_pkg::CTRL_CMP2_INV_BIT:cmp_ctrl_pkg::CTRL_CMP1_INV_BIT];
            state_reg.input_switch          <= cmp_ctrl_pkg::CTRL_RESET[cmp_ctrl_pkg::CTRL_IN_SWITCH_BIT];
            state_reg.mode                  <= cmp_ctrl_pkg::MODE_RESET; // [R17]
            state_reg.flag                  <= cmp_ctrl_pkg::INT_RESET[cmp_ctrl_pkg::INT_FLAG_BIT];
            state_reg.cmp_int_enable        <= cmp_ctrl_pkg::INT_RESET[cmp_ctrl_pkg::INT_CMP_EN_BIT];
            state_reg.peripheral_int_enable <= cmp_ctrl_pkg::INT_RESET[cmp_ctrl_pkg::INT_PERIPH_EN_BIT];
            state_reg.global_int_enable     <= cmp_ctrl_pkg::INT_RESET[cmp_ctrl_pkg::INT_GLOBAL_EN_BIT];
            state_reg.port_direction_bits   <= cmp_ctrl_pkg::DIR_RESET;
        end
        else
        begin
            state_reg <= state_next; // [R16]
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata                = state_reg.rdata;
    assign comparator_mode_field = state_reg.mode; // [R4]
    // comparators keep running in sleep; only modes 000 and 111 stop them
    assign cmp_power_en          = {2{is_powered}}; // [R14] [R15] [R17]
    assign ref_to_noninv         = (state_reg.mode == cmp_ctrl_pkg::MODE_INT_REF); // [R6]
    assign input_switch_alt      = (state_reg.mode == cmp_ctrl_pkg::MODE_INT_REF) && state_reg.input_switch; // [R5]
    assign analog_pin_mask       = mask_of(state_reg.mode); // [R20]

    // straight from the comparator, no synchroniser in the path
    assign cmp1_output_pin_o  = is_powered && (cmp1_raw ^ state_reg.invert[0]); // [R18]
    assign cmp2_output_pin_o  = is_powered && (cmp2_raw ^ state_reg.invert[1]); // [R18]
    // direction bit low means drive, as for an ordinary port pin
    assign cmp1_output_pin_oe = route[0] && !state_reg.port_direction_bits[cmp_ctrl_pkg::PIN_CMP1_OUT]; // [R19]
    assign cmp2_output_pin_oe = route[1] && !state_reg.port_direction_bits[cmp_ctrl_pkg::PIN_CMP2_OUT]; // [R19]

    assign irq          = state_reg.flag && state_reg.cmp_int_enable
                          && state_reg.peripheral_int_enable && state_reg.global_int_enable; // [R11]
    assign wake_request = state_reg.flag && state_reg.cmp_int_enable; // [R14]

endmodule
`default_nettype wire

// *** bench/cmp_partner.sv ***
`timescale 1ns/1ps
`default_nettype none
module cmp_partner
(
    // clock and power
    input  wire logic       pclk,
    input  wire logic [1:0] pwr,
    // analog levels as codes
    input  wire logic [7:0] plus1,
    input  wire logic [7:0] minus1,
    input  wire logic [7:0] plus2,
    input  wire logic [7:0] minus2,
    // comparator outputs
    output logic            cmp1_raw,
    output logic            cmp2_raw
);
    logic junk = 1'b0;
    // an unpowered comparator gives no level worth trusting, so it wanders
    always @(posedge pclk) junk <= ~junk;
    always_comb
    begin
        cmp1_raw = pwr[0] ? (plus1 > minus1) : junk;
        cmp2_raw = pwr[1] ? (plus2 > minus2) : ~junk;
    end
endmodule
`default_nettype wire

// *** bench/cmp_ctrl_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module cmp_ctrl_checker #(
    parameter logic [63:0] ANALOG_MASK_TABLE = 64'h0
)
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        pslverr,
    // comparator side
    input wire logic        cmp1_raw,
    input wire logic [2:0]  comparator_mode_field,
    input wire logic [1:0]  cmp_power_en,
    input wire logic        ref_to_noninv,
    input wire logic        input_switch_alt,
    input wire logic [7:0]  analog_pin_mask,
    input wire logic        cmp1_output_pin_o,
    input wire logic        irq,
    input wire logic        wake_request
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_acc;
    assign wr_acc = psel && penable && pwrite;
    sequence ctrl_write;
        wr_acc && paddr == 12'h000 && pstrb[0];
    endsequence
    // writes to the invert bits move the pin too, so skip those cycles
    sequence raw_edge;
        $changed(cmp1_raw) && cmp_power_en[0] && $past(cmp_power_en[0]) && !$past(wr_acc);
    endsequence
    a_mode_write: assert property (ctrl_write |=> comparator_mode_field == $past(pwdata[2:0]))
        else $error("mode not taken from write");
    a_mode_hold: assert property (!wr_acc |=> $stable(comparator_mode_field))
        else $error("mode moved without a write");
    a_power_mode: assert property (cmp_power_en == ((comparator_mode_field inside {3'h0, 3'h7}) ? 2'h0 : 2'h3))
        else $error("power enable wrong for mode");
    a_ref_mode: assert property (ref_to_noninv == (comparator_mode_field == 3'h6))
        else $error("reference select wrong for mode");
    a_switch_mode: assert property (input_switch_alt |-> comparator_mode_field == 3'h6)
        else $error("input switch outside its mode");
    a_mask_table: assert property (analog_pin_mask == ANALOG_MASK_TABLE[comparator_mode_field * 8 +: 8])
        else $error("analog mask not from table");
    a_pin_unsync: assert property (raw_edge |-> $changed(cmp1_output_pin_o))
        else $error("pin output lags comparator");
    a_irq_gate: assert property (irq |-> wake_request)
        else $error("request without change enable");
    a_reset_state: assert property ($rose(presetn) |-> comparator_mode_field == 3'h0 && cmp_power_en == 2'h0 && !irq)
        else $error("reset state wrong");
    a_apb_answer: assert property (psel && penable |-> pready && pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C}))
        else $error("apb answer wrong");
endmodule
bind cmp_ctrl cmp_ctrl_checker #(.ANALOG_MASK_TABLE(ANALOG_MASK_TABLE)) chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .cmp1_raw(cmp1_raw), .comparator_mode_field(comparator_mode_field),
    .cmp_power_en(cmp_power_en), .ref_to_noninv(ref_to_noninv), .input_switch_alt(input_switch_alt),
    .analog_pin_mask(analog_pin_mask), .cmp1_output_pin_o(cmp1_output_pin_o), .irq(irq),
    .wake_request(wake_request));
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((e) !== (s)) begin miscompares++; $display("[ERR] %s exp %h got %h", nm, e, s); end end
module tb;
    localparam logic [63:0] AMT = cmp_ctrl_pkg::ANALOG_MASK_TABLE;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hF;
    logic [7:0]  pins = 8'h00;
    logic [7:0]  p1 = 8'h80, m1 = 8'h40, p2 = 8'h20, m2 = 8'h60;
    logic [31:0] prdata, e, w;
    logic [2:0]  mode;
    logic [1:0]  pwr;
    logic [7:0]  amask;
    logic        pready, pslverr, serr, cmp1_raw, cmp2_raw, ref_sel, sw_alt, o1, oe1, o2, oe2, irq, wake;
    logic [31:0] expq[$];
    int          miscompares = 0, checked = 0;
    always #20 pclk = ~pclk;
    // mode 5 routes both outputs to their pins
    cmp_ctrl #(.PIN_ROUTE_TABLE(16'h0C00)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp1_raw(cmp1_raw), .cmp2_raw(cmp2_raw), .port_pin_in(pins),
        .comparator_mode_field(mode), .cmp_power_en(pwr), .ref_to_noninv(ref_sel), .input_switch_alt(sw_alt),
        .analog_pin_mask(amask), .cmp1_output_pin_o(o1), .cmp1_output_pin_oe(oe1), .cmp2_output_pin_o(o2),
        .cmp2_output_pin_oe(oe2), .irq(irq), .wake_request(wake));
    cmp_partner model (.pclk(pclk), .pwr(pwr), .plus1(p1), .minus1(m1), .plus2(p2), .minus2(m2),
        .cmp1_raw(cmp1_raw), .cmp2_raw(cmp2_raw));
    task automatic conclude();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int   n;
        logic got;
        n = 0;
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        // request stands until pready is seen high at a rising edge, giving up after 50 edges
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        got = pready;
        serr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        // idle edge, so the next call never re-raises psel in this step
        @(posedge pclk);
        if (got !== 1'b1) begin miscompares++; conclude(); end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hF);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        expq.push_back(x);
        xfer(1'b0, a, 32'h0, 4'hF);
    endtask
    function automatic logic [31:0] ctrl_exp(input logic [7:0] v);
        logic [1:0] st;
        st = {p2 > m2, p1 > m1} ^ v[5:4];
        if (v[2:0] == 3'h0 || v[2:0] == 3'h7) st = 2'h0;
        return {24'h0, st, v[5:0]};
    endfunction
    // ------------------------------------------------------------
    // read data monitor
    // ------------------------------------------------------------
    always @(negedge pclk)
    begin
        if (psel && penable && pready && !pwrite)
        begin
            e = (expq.size() > 0) ? expq.pop_front() : 32'hFFFF_FFFF;
            `CHK("prdata", e, prdata)
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h921BD467));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h000, 32'h0);
        rd(12'h004, 32'h0);
        rd(12'h008, 32'hFF);
        `CHK("power", 2'h0, pwr)
        // interrupt enables stay clear while the mode moves
        for (int m = 0; m < 8; m++)
        begin
            w = $urandom();
            w[2:0] = m[2:0];
            // the alternate inputs only show in mode 110, so make sure it is asked for there
            if (m == 6) w[3] = 1'b1;
            pins <= 8'($urandom());
            wr(12'h000, w);
            repeat (4) @(posedge pclk);
            `CHK("mode", m[2:0], mode)
            `CHK("ref", m == 6, ref_sel)
            `CHK("alt", m == 6 && w[3], sw_alt)
            `CHK("power", (m == 0 || m == 7) ? 2'h0 : 2'h3, pwr)
            `CHK("mask", AMT[m*8 +: 8], amask)
            rd(12'h000, ctrl_exp(w[7:0]));
            rd(12'h00C, {24'h0, pins & ~AMT[m*8 +: 8]});
        end
        wr(12'h000, 32'h1);
        xfer(1'b1, 12'h000, 32'h5, 4'hE);
        wr(12'h00C, 32'hFF);
        rd(12'h000, ctrl_exp(8'h01));
        rd(12'h010, 32'h0);
        `CHK("slverr", 1'b1, serr)
        wr(12'h004, 32'hE);
        rd(12'h004, 32'hE);
        p1 <= 8'h10;
        repeat (3) @(negedge pclk);
        `CHK("irq", 1'b0, irq)
        @(negedge pclk);
        `CHK("irq", 1'b1, irq)
        `CHK("wake", 1'b1, wake)
        @(posedge pclk);
        wr(12'h004, 32'hE);
        rd(12'h004, 32'hF);
        rd(12'h000, ctrl_exp(8'h01));
        wr(12'h004, 32'hE);
        rd(12'h004, 32'hE);
        for (int k = 0; k < 16; k++)
        begin
            wr(12'h004, k);
            @(negedge pclk);
            `CHK("irq", k == 15, irq)
            `CHK("wake", k[1:0] == 2'h3, wake)
            @(posedge pclk);
        end
        wr(12'h004, 32'h0);
        wr(12'h000, 32'h15);
        wr(12'h008, 32'hF9);
        @(negedge pclk);
        `CHK("oe1", 1'b1, oe1)
        `CHK("oe2", 1'b1, oe2)
        `CHK("pin1", ~(p1 > m1), o1)
        @(posedge pclk);
        p2 <= 8'h70;
        #1;
        `CHK("pin2", 1'b1, o2)
        @(posedge pclk);
        wr(12'h008, 32'hFF);
        `CHK("oe1", 1'b0, oe1)
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(12'h000, 32'h0);
        rd(12'h008, 32'hFF);
        `CHK("pending", 0, expq.size())
        conclude();
    end
endmodule
`default_nettype wire
